/* hw/ittd_pkg.sv */
// Purpose: Constants and types for the interrupt-triggered transfer controller
// Assumes: Descriptors and data share one 32-bit memory request port
// Notes on behaviour
// - Mode field of word A: 00 normal, 01 repeat, 10 block.
// - Size field of word A: 00 byte, 01 word, 10 longword.
// - Source pointer: 0x fixed, 10 increment, 11 decrement after each element.
// - Address step equals element size: 1, 2 or 4.
// - Fixed source pointer is not written back to the descriptor.
// - Destination pointer: 0x fixed, 10 increment, 11 decrement after each element.
// - Fixed destination pointer is not written back to the descriptor.
// - Word B bit 7 set allows chaining to the next descriptor.
// - Chain condition 0 chains always; 1 chains only when count reached zero.
// - Chained transfer skips completion check, enable clear and source flag clear.
// - Per-transfer select 1 raises a CPU interrupt after every transfer.
// - Per-transfer select 0 raises CPU interrupt only at programmed count end.
// - Area side 0 makes destination the repeat/block area, 1 the source.
// - Activation fetches descriptor address through vector, reads descriptor, moves data.
// - Updated descriptor is written back after the data transfer.
// - Mode, pointer and count words live only in memory, not CPU registers.
// - On-chip RAM descriptors use a 32-bit path, one state per access.
// - Short address mode sign-extends bit 23 into the upper eight bits.
// - Normal mode count decrements; reaching zero clears enable, requests interrupt.
// - Repeat mode low counter decrements and reloads from high byte at zero.
`default_nettype none
package ittd_pkg;
  // Transfer mode codes in word A
  localparam logic [1:0] ITTD_MODE_NORMAL = 2'h0;
  localparam logic [1:0] ITTD_MODE_REPEAT = 2'h1;
  localparam logic [1:0] ITTD_MODE_BLOCK = 2'h2;
  // Element size codes, also used on the memory size port
  localparam logic [1:0] ITTD_SIZE_BYTE = 2'h0;
  localparam logic [1:0] ITTD_SIZE_WORD = 2'h1;
  localparam logic [1:0] ITTD_SIZE_LONG = 2'h2;
  // Pointer step modes (upper bit 0 means fixed)
  localparam logic [1:0] ITTD_STEP_INC = 2'h2;
  localparam logic [1:0] ITTD_STEP_DEC = 2'h3;
  // Word A field positions
  localparam int ITTD_A_MODE_HI = 7;
  localparam int ITTD_A_MODE_LO = 6;
  localparam int ITTD_A_SIZE_HI = 5;
  localparam int ITTD_A_SIZE_LO = 4;
  localparam int ITTD_A_SRC_HI = 3;
  localparam int ITTD_A_SRC_LO = 2;
  // Word B field positions
  localparam int ITTD_B_CHAIN_EN = 7;
  localparam int ITTD_B_CHAIN_COND = 6;
  localparam int ITTD_B_IRQ_SEL = 5;
  localparam int ITTD_B_AREA_SIDE = 4;
  localparam int ITTD_B_DST_HI = 3;
  localparam int ITTD_B_DST_LO = 2;
  // Descriptor geometry: index of the last word per descriptor and byte stride of a descriptor
  localparam logic [1:0] ITTD_DESC_LAST_FULL = 2'h3;
  localparam logic [1:0] ITTD_DESC_LAST_SHORT = 2'h2;
  localparam logic [31:0] ITTD_DESC_BYTES_FULL = 32'h0000_0010;
  localparam logic [31:0] ITTD_DESC_BYTES_SHORT = 32'h0000_000c;
  localparam int ITTD_SHORT_MSB = 23;
  // Writeback slot order
  localparam logic [1:0] ITTD_WB_SRC = 2'h0;
  localparam logic [1:0] ITTD_WB_DST = 2'h1;
  localparam logic [1:0] ITTD_WB_CNT = 2'h2;
  // Count values that mark the last element
  localparam logic [15:0] ITTD_CNT16_LAST = 16'h0001;
  localparam logic [7:0] ITTD_CNT8_LAST = 8'h01;
  // Buffer defaults
  localparam int ITTD_BUF_WIDTH = 32;
  localparam int ITTD_BUF_DEPTH = 2;
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ITTD_IDLE = 7'h01,
    ITTD_VEC = 7'h02,
    ITTD_DESC = 7'h04,
    ITTD_RD = 7'h08,
    ITTD_WR = 7'h10,
    ITTD_WB = 7'h20,
    ITTD_END = 7'h40
  } ittd_state_t;
endpackage
`default_nettype wire

/* hw/ittd_buf2.sv */
// Purpose: Small valid/ready buffer between element read and element write
// Assumes: DEPTH of at least 2; push and pop may happen in one cycle
// Notes: Full and empty are exact, so the reader stalls when no slot is free
`timescale 1ns/1ns
`default_nettype none
module ittd_buf2 #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fill;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  wire [PW-1:0] next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0] next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  // Honest status flags
  assign o_in_ready = (fill != (PW + 1)'(DEPTH));
  assign o_out_valid = (fill != '0);
  assign o_out_data = mem[rd_ptr];

  // Storage has no reset; only the pointers matter
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= next_wr_ptr;
      end
      if (pop) begin
        rd_ptr <= next_rd_ptr;
      end
      fill <= fill + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* hw/ittd_engine.sv */
// Purpose: Activation-driven transfer engine working from in-memory descriptors
// Assumes: Memory holds o_mem_req until a one-cycle i_mem_ack; RAM answers next cycle
// Notes: Mode and count words are never CPU-visible; they live only in memory
`timescale 1ns/1ns
`default_nettype none
module ittd_engine
  import ittd_pkg::*;
#(
  parameter int BUF_WIDTH = ITTD_BUF_WIDTH,
  parameter int BUF_DEPTH = ITTD_BUF_DEPTH
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Activation request from the interrupt side
  input wire logic i_act_valid,
  input wire logic [31:0] i_act_vector,
  output logic o_act_ready,
  // Configuration
  input wire logic i_short_addr_mode,
  // Memory request port
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [31:0] o_mem_addr,
  output logic [1:0] o_mem_size,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  // Completion outputs
  output logic o_cpu_irq,
  output logic o_enable_clear,
  output logic o_src_flag_clear
);
  // Sign-extend a short-mode address
  function automatic logic [31:0] sext24(input logic [31:0] a);
    return {{8{a[ITTD_SHORT_MSB]}}, a[ITTD_SHORT_MSB:0]};
  endfunction

  // Byte step for one element
  function automatic logic [31:0] elem_step(input logic [1:0] sz);
    unique case (sz)
      ITTD_SIZE_WORD: return 32'h0000_0002;
      ITTD_SIZE_LONG: return 32'h0000_0004;
      default: return 32'h0000_0001;
    endcase
  endfunction

  // Pointer after one element
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] m,
                                            input logic [1:0] sz);
    if (m == ITTD_STEP_INC) begin
      return a + elem_step(sz);
    end else if (m == ITTD_STEP_DEC) begin
      return a - elem_step(sz);
    end
    return a;
  endfunction

  ittd_state_t state;
  logic [31:0] desc_addr;
  logic [1:0] word_idx;
  logic [7:0] mode_a;
  logic [7:0] mode_b;
  logic [31:0] src;
  logic [31:0] dst;
  logic [31:0] src_base;
  logic [31:0] dst_base;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic done_all;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [BUF_WIDTH-1:0] buf_out_data;

  wire [1:0] xfer_mode = mode_a[ITTD_A_MODE_HI:ITTD_A_MODE_LO];
  wire [1:0] elem_size = mode_a[ITTD_A_SIZE_HI:ITTD_A_SIZE_LO];
  wire [1:0] src_mode = mode_a[ITTD_A_SRC_HI:ITTD_A_SRC_LO];
  wire [1:0] dst_mode = mode_b[ITTD_B_DST_HI:ITTD_B_DST_LO];
  wire is_repeat = (xfer_mode == ITTD_MODE_REPEAT);
  wire is_block = (xfer_mode == ITTD_MODE_BLOCK);
  wire chain_en = mode_b[ITTD_B_CHAIN_EN];
  wire chain_cond = mode_b[ITTD_B_CHAIN_COND];
  wire irq_sel = mode_b[ITTD_B_IRQ_SEL];
  wire area_is_src = mode_b[ITTD_B_AREA_SIDE];
  wire src_fixed = !src_mode[1];
  wire dst_fixed = !dst_mode[1];

  // Memory handshake decode
  wire acked = o_mem_req && i_mem_ack;
  wire [1:0] desc_last = i_short_addr_mode ? ITTD_DESC_LAST_SHORT : ITTD_DESC_LAST_FULL;
  wire [31:0] desc_bytes = i_short_addr_mode ? ITTD_DESC_BYTES_SHORT : ITTD_DESC_BYTES_FULL;
  wire [31:0] word_addr = desc_addr + {28'h000_0000, word_idx, 2'h0};
  wire [1:0] wb_phys = i_short_addr_mode ? word_idx : word_idx + 2'h1;
  wire [31:0] wb_addr = desc_addr + {28'h000_0000, wb_phys, 2'h0};
  wire [31:0] rd_ptr_val = i_short_addr_mode ? sext24(i_mem_rdata) : i_mem_rdata;

  // writeback slots skipped for fixed pointers
  wire wb_skip = ((word_idx == ITTD_WB_SRC) && src_fixed) ||
                 ((word_idx == ITTD_WB_DST) && dst_fixed);
  wire [31:0] wb_data = (word_idx == ITTD_WB_SRC) ?
                          (i_short_addr_mode ? {mode_a, src[23:0]} : src) :
                        (word_idx == ITTD_WB_DST) ?
                          (i_short_addr_mode ? {mode_b, dst[23:0]} : dst) :
                        {cnt_a, cnt_b};

  // counter decisions for the element just written
  wire low_last = (cnt_a[7:0] == ITTD_CNT8_LAST);
  wire [7:0] next_low = low_last ? cnt_a[15:8] : cnt_a[7:0] - 8'h01;
  wire block_end = is_block && low_last;
  wire next_done = is_block ? (block_end && (cnt_b == ITTD_CNT16_LAST)) :
                   (!is_repeat && (cnt_a == ITTD_CNT16_LAST));
  // area side returns to its start at the end of a repeat run or block
  wire restore = (is_repeat || is_block) && low_last;
  wire [31:0] next_src = (restore && area_is_src) ? src_base :
                         step_addr(src, src_mode, elem_size);
  wire [31:0] next_dst = (restore && !area_is_src) ? dst_base :
                         step_addr(dst, dst_mode, elem_size);

  wire chain_next = chain_en && (!chain_cond || done_all);
  // interrupt choice; enable clear with it
  wire finish_irq = irq_sel || done_all;

  // Element staging buffer: a stalled write holds the read side off
  ittd_buf2 #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(state == ITTD_RD && o_mem_req && !o_mem_we && i_mem_ack),
    .i_in_data(i_mem_rdata[BUF_WIDTH-1:0]),
    .o_in_ready(buf_in_ready),
    .o_out_valid(buf_out_valid),
    .o_out_data(buf_out_data),
    .i_out_ready(state == ITTD_WR && o_mem_req && o_mem_we && i_mem_ack)
  );

  // Sequencer and memory request
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state <= ITTD_IDLE;
      o_act_ready <= 1'b1;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= 32'h0000_0000;
      o_mem_size <= ITTD_SIZE_LONG;
      o_mem_wdata <= 32'h0000_0000;
      o_cpu_irq <= 1'b0;
      o_enable_clear <= 1'b0;
      o_src_flag_clear <= 1'b0;
      desc_addr <= 32'h0000_0000;
      word_idx <= 2'h0;
      mode_a <= 8'h00;
      mode_b <= 8'h00;
      src <= 32'h0000_0000;
      dst <= 32'h0000_0000;
      src_base <= 32'h0000_0000;
      dst_base <= 32'h0000_0000;
      cnt_a <= 16'h0000;
      cnt_b <= 16'h0000;
      done_all <= 1'b0;
    end else begin
      o_cpu_irq <= 1'b0;
      o_enable_clear <= 1'b0;
      o_src_flag_clear <= 1'b0;
      unique case (state)
        ITTD_IDLE: begin
          if (i_act_valid && o_act_ready) begin
            o_act_ready <= 1'b0;
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b0;
            o_mem_size <= ITTD_SIZE_LONG;
            o_mem_addr <= i_act_vector;
            state <= ITTD_VEC;
          end
        end
        ITTD_VEC: begin
          if (acked) begin
            desc_addr <= rd_ptr_val;
            word_idx <= 2'h0;
            o_mem_req <= 1'b0;
            state <= ITTD_DESC;
          end
        end
        ITTD_DESC: begin
          // descriptor words, one longword per access
          if (!o_mem_req) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b0;
            o_mem_size <= ITTD_SIZE_LONG;
            o_mem_addr <= word_addr;
          end else if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            word_idx <= word_idx + 2'h1;
            if (word_idx == desc_last) begin
              word_idx <= 2'h0;
              done_all <= 1'b0;
              state <= ITTD_RD;
            end
            if (i_short_addr_mode) begin
              // short layout: mode byte over a 24-bit pointer
              unique case (word_idx)
                2'h0: begin
                  mode_a <= i_mem_rdata[31:24];
                  src <= rd_ptr_val;
                  src_base <= rd_ptr_val;
                end
                2'h1: begin
                  mode_b <= i_mem_rdata[31:24];
                  dst <= rd_ptr_val;
                  dst_base <= rd_ptr_val;
                end
                default: begin
                  cnt_a <= i_mem_rdata[31:16];
                  cnt_b <= i_mem_rdata[15:0];
                end
              endcase
            end else begin
              unique case (word_idx)
                2'h0: begin
                  mode_a <= i_mem_rdata[31:24];
                  mode_b <= i_mem_rdata[23:16];
                end
                2'h1: begin
                  src <= i_mem_rdata;
                  src_base <= i_mem_rdata;
                end
                2'h2: begin
                  dst <= i_mem_rdata;
                  dst_base <= i_mem_rdata;
                end
                default: begin
                  cnt_a <= i_mem_rdata[31:16];
                  cnt_b <= i_mem_rdata[15:0];
                end
              endcase
            end
          end
        end
        ITTD_RD: begin
          // element read, held off while the buffer is full
          if (!o_mem_req && buf_in_ready) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b0;
            o_mem_size <= elem_size;
            o_mem_addr <= src;
          end else if (acked) begin
            o_mem_req <= 1'b0;
            state <= ITTD_WR;
          end
        end
        ITTD_WR: begin
          if (!o_mem_req && buf_out_valid) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b1;
            o_mem_size <= elem_size;
            o_mem_addr <= dst;
            o_mem_wdata <= buf_out_data;
          end else if (acked) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            src <= next_src;
            dst <= next_dst;
            if (is_repeat || is_block) begin
              cnt_a <= {cnt_a[15:8], next_low};
            end else begin
              cnt_a <= cnt_a - 16'h0001;
            end
            if (block_end) begin
              cnt_b <= cnt_b - 16'h0001;
            end
            done_all <= next_done;
            word_idx <= 2'h0;
            state <= (is_block && !low_last) ? ITTD_RD : ITTD_WB;
          end
        end
        ITTD_WB: begin
          if (!o_mem_req && wb_skip) begin
            word_idx <= word_idx + 2'h1;
          end else if (!o_mem_req) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b1;
            o_mem_size <= ITTD_SIZE_LONG;
            o_mem_addr <= wb_addr;
            o_mem_wdata <= wb_data;
          end else if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            word_idx <= word_idx + 2'h1;
            if (word_idx == ITTD_WB_CNT) begin
              word_idx <= 2'h0;
              state <= ITTD_END;
            end
          end
        end
        ITTD_END: begin
          if (chain_next) begin
            desc_addr <= desc_addr + desc_bytes;
            state <= ITTD_DESC;
          end else begin
            o_cpu_irq <= finish_irq;
            o_enable_clear <= finish_irq;
            o_src_flag_clear <= !finish_irq;
            o_act_ready <= 1'b1;
            state <= ITTD_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* bench/ittd_engine_chk.sv */
// Purpose: Port-level timing checks for the transfer engine
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every ittd_engine instance
`timescale 1ns/1ns
`default_nettype none
module ittd_engine_chk (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Activation side
  input wire logic i_act_valid,
  input wire logic [31:0] i_act_vector,
  input wire logic i_short_addr_mode,
  input wire logic o_act_ready,
  // Memory port
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [31:0] o_mem_addr,
  input wire logic [1:0] o_mem_size,
  input wire logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  // Completion pulses
  input wire logic o_cpu_irq,
  input wire logic o_enable_clear,
  input wire logic o_src_flag_clear
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Protocol and completion relations
  chk_vector_fetch: assert property (i_act_valid && o_act_ready && !i_short_addr_mode |=>
    !o_act_ready && o_mem_req && !o_mem_we && o_mem_addr == $past(i_act_vector))
    else $error("vector read missing after activation");
  chk_req_held: assert property (o_mem_req && !i_mem_ack |=> o_mem_req
    && $stable(o_mem_addr) && $stable(o_mem_wdata) && $stable(o_mem_we) && $stable(o_mem_size))
    else $error("memory request changed before acknowledge");
  chk_req_gap: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
    else $error("memory request not dropped after acknowledge");
  chk_irq_pair: assert property (o_cpu_irq |-> o_enable_clear && !o_src_flag_clear)
    else $error("interrupt without enable clear");
  chk_clear_pair: assert property (o_enable_clear |-> o_cpu_irq)
    else $error("enable clear without interrupt");
  chk_done_after_wb: assert property ((o_cpu_irq || o_src_flag_clear) |->
    $past(o_mem_we, 2) && $past(i_mem_ack, 2) && o_act_ready)
    else $error("completion pulse not after writeback");
  chk_pulse_once: assert property (o_cpu_irq |=> !o_cpu_irq)
    else $error("interrupt pulse longer than one cycle");
  chk_idle_quiet: assert property (o_act_ready |-> !o_mem_req)
    else $error("memory request while idle");
  chk_job_bounded: assert property ($fell(o_act_ready) |-> ##[1:400] o_act_ready)
    else $error("transfer job did not finish");
  chk_size_legal: assert property (o_mem_req |-> o_mem_size != 2'h3)
    else $error("illegal access size");
endmodule
bind ittd_engine ittd_engine_chk chk_u (.i_sys_clk, .i_reset_n, .i_act_valid, .i_act_vector,
  .i_short_addr_mode, .o_act_ready, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_size,
  .o_mem_wdata, .i_mem_ack, .o_cpu_irq, .o_enable_clear, .o_src_flag_clear);
`default_nettype wire

/* bench/ittd_mem_model.sv */
// Purpose: Memory stand-in for the transfer engine
// Assumes: Request held until a one-cycle acknowledge
// Notes: Read data is scrambled outside the acknowledge cycle
`timescale 1ns/1ns
`default_nettype none
module ittd_mem_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Request side
  input wire logic i_mem_req,
  input wire logic i_mem_we,
  input wire logic [31:0] i_mem_addr,
  input wire logic [31:0] i_mem_wdata,
  input wire logic [1:0] i_mem_size,
  input wire logic [3:0] i_delay,
  // Answer side
  output logic o_mem_ack,
  output logic [31:0] o_mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wr_addr [$];
  logic [31:0] wr_data [$];
  logic [31:0] rd_addr [$];
  logic [1:0] rd_size [$];
  logic [3:0] wait_cnt;

  // write data is logged only; mem is never updated by a write
  // Answer after a chosen wait, log every completed access
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= 32'h0;
      wait_cnt <= 4'h0;
    end else if (o_mem_ack) begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= ~o_mem_rdata;
      if (i_mem_we) begin
        wr_addr.push_back(i_mem_addr);
        wr_data.push_back(i_mem_wdata);
      end else begin
        rd_addr.push_back(i_mem_addr);
        rd_size.push_back(i_mem_size);
      end
    end else if (i_mem_req && wait_cnt == i_delay) begin
      o_mem_ack <= 1'b1;
      wait_cnt <= 4'h0;
      o_mem_rdata <= mem.exists(i_mem_addr) ? mem[i_mem_addr] : ~i_mem_addr;
    end else begin
      wait_cnt <= i_mem_req ? wait_cnt + 4'h1 : 4'h0;
      o_mem_rdata <= ~o_mem_rdata; // No stale data between answers
    end
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Purpose: Self-checking bench for the transfer engine
// Assumes: Memory stand-in answers after a bench-chosen wait
// Notes: Rows cover normal mode; repeat, block, chain, short mode follow
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] wa;
    logic [7:0] wb;
    logic [15:0] cnt;
    logic irq;
    logic flag;
  } ittd_row_t;
  localparam logic [31:0] VEC = 32'h0000_0040;
  localparam logic [31:0] DSC = 32'h0000_0100;
  localparam logic [31:0] SRC = 32'h0000_1000;
  localparam logic [31:0] DST = 32'h0000_2000;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_act_valid = 1'b0;
  logic [31:0] i_act_vector = 32'h0;
  logic i_short_addr_mode = 1'b0;
  logic [3:0] delay = 4'h0;
  logic o_act_ready, o_mem_req, o_mem_we, i_mem_ack;
  logic [31:0] o_mem_addr, o_mem_wdata, i_mem_rdata;
  logic [1:0] o_mem_size;
  logic o_cpu_irq, o_enable_clear, o_src_flag_clear;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_irq, n_clr, n_flag;
  // reserved mode bits written as zero
  ittd_row_t rows [5] = '{
    '{8'h08, 8'h0c, 16'h0001, 1'b1, 1'b0},
    '{8'h1c, 8'h28, 16'h0002, 1'b1, 1'b0},
    '{8'h20, 8'h00, 16'h0002, 1'b0, 1'b1},
    '{8'h28, 8'h08, 16'h0001, 1'b1, 1'b0},
    '{8'h04, 8'h04, 16'h0002, 1'b0, 1'b1}};

  ittd_engine dut_u (.i_sys_clk, .i_reset_n, .i_act_valid, .i_act_vector, .o_act_ready,
    .i_short_addr_mode, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_size, .o_mem_wdata,
    .i_mem_ack, .i_mem_rdata, .o_cpu_irq, .o_enable_clear, .o_src_flag_clear);
  ittd_mem_model mem_u (.i_sys_clk, .i_reset_n, .i_mem_req(o_mem_req), .i_mem_we(o_mem_we),
    .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .i_mem_size(o_mem_size),
    .i_delay(delay), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));

  // Clock, 8 ns period
  always #4 i_sys_clk = ~i_sys_clk;

  // Pulse tally and hang guard
  always @(posedge i_sys_clk) begin
    if (o_cpu_irq === 1'b1) n_irq++;
    if (o_enable_clear === 1'b1) n_clr++;
    if (o_src_flag_clear === 1'b1) n_flag++;
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic put_desc(input logic [31:0] d, s, t, c, input logic [7:0] wa, wb);
    mem_u.mem[d] = {wa, wb, 16'h0};
    mem_u.mem[d + 32'h4] = s;
    mem_u.mem[d + 32'h8] = t;
    mem_u.mem[d + 32'hc] = c;
  endtask

  // One activation, raised for one cycle, then wait for idle
  task automatic activate();
    int n;
    n = 0;
    mem_u.wr_addr.delete();
    mem_u.wr_data.delete();
    mem_u.rd_addr.delete();
    mem_u.rd_size.delete();
    n_irq = 0;
    n_clr = 0;
    n_flag = 0;
    @(negedge i_sys_clk);
    i_act_valid = 1'b1;
    i_act_vector = VEC;
    @(negedge i_sys_clk);
    i_act_valid = 1'b0;
    while (o_act_ready !== 1'b1 && n < 500) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n >= 500) chk(32'h0, 32'h1);
    @(negedge i_sys_clk);
  endtask

  initial begin
    int st;
    int k;
    logic [31:0] msk;
    mem_u.mem[VEC] = DSC;
    repeat (4) @(negedge i_sys_clk);
    chk({27'h0, o_act_ready, o_mem_req, o_mem_we, o_mem_size}, 32'h12);
    i_reset_n = 1'b1;
    // Normal-mode table
    for (int r = 0; r < 5; r++) begin
      st = 1 << rows[r].wa[5:4];
      msk = ~(32'hffff_ffff << (8 * st));
      delay = 4'(r);
      put_desc(DSC, SRC, DST, {rows[r].cnt, 16'h0}, rows[r].wa, rows[r].wb);
      mem_u.mem[SRC] = 32'hc3a5_5a96 ^ 32'(r);
      activate();
      k = 1;
      chk(mem_u.rd_addr[0], VEC);
      chk({30'h0, mem_u.rd_size[0]}, 32'h2);
      chk({30'h0, mem_u.rd_size[5]}, {30'h0, rows[r].wa[5:4]});
      chk(mem_u.rd_addr[5], SRC);
      chk(mem_u.wr_addr[0], DST);
      chk(mem_u.wr_data[0] & msk, mem_u.mem[SRC] & msk);
      if (rows[r].wa[3]) begin
        chk(mem_u.wr_addr[k], DSC + 32'h4);
        chk(mem_u.wr_data[k], rows[r].wa[2] ? SRC - st : SRC + st);
        k++;
      end
      if (rows[r].wb[3]) begin
        chk(mem_u.wr_addr[k], DSC + 32'h8);
        chk(mem_u.wr_data[k], rows[r].wb[2] ? DST - st : DST + st);
        k++;
      end
      chk(mem_u.wr_addr[k], DSC + 32'hc);
      chk(mem_u.wr_data[k], {rows[r].cnt - 16'h1, 16'h0});
      chk(mem_u.wr_addr.size(), k + 1);
      chk(n_irq, rows[r].irq);
      chk(n_clr, rows[r].irq);
      chk(n_flag, rows[r].flag);
    end
    // Repeat: destination area restored, low count reloaded
    put_desc(DSC, SRC, DST, 32'h0201_0000, 8'h48, 8'h08);
    activate();
    chk(mem_u.wr_data[1], SRC + 32'h1);
    chk(mem_u.wr_data[2], DST);
    chk(mem_u.wr_data[3], 32'h0202_0000);
    chk(n_flag, 1);
    // Block of two longwords, slow memory, source is block area
    delay = 4'h3;
    mem_u.mem[SRC + 32'h4] = 32'h0bad_f00d;
    put_desc(DSC, SRC, DST, 32'h0202_0001, 8'ha8, 8'h18);
    activate();
    chk(mem_u.wr_addr[1], DST + 32'h4);
    chk(mem_u.wr_data[1], 32'h0bad_f00d);
    chk(mem_u.wr_data[2], SRC);
    chk(mem_u.wr_data[3], DST + 32'h8);
    chk(mem_u.wr_data[4], 32'h0202_0000);
    chk(n_irq, 1);
    // Chain every time, then chain only at zero count
    delay = 4'h1;
    put_desc(DSC + 32'h10, SRC, DST, 32'h0001_0000, 8'h00, 8'h00);
    put_desc(DSC, SRC, DST, 32'h0002_0000, 8'h00, 8'h80);
    activate();
    chk(mem_u.wr_addr[3], DSC + 32'h1c);
    chk(n_irq, 1);
    chk(n_flag, 0);
    put_desc(DSC, SRC, DST, 32'h0002_0000, 8'h00, 8'hc0);
    activate();
    chk(mem_u.wr_addr.size(), 2);
    chk(n_flag, 1);
    // Short addresses sign-extend bit 23
    i_short_addr_mode = 1'b1;
    mem_u.mem[DSC] = 32'h0880_0010;
    mem_u.mem[DSC + 32'h4] = 32'h0000_2000;
    mem_u.mem[DSC + 32'h8] = 32'h0001_0000;
    activate();
    chk(mem_u.rd_addr[4], 32'hff80_0010);
    chk(mem_u.wr_addr[0], DST);
    print_verdict();
  end
endmodule
`default_nettype wire
